// file: rtl/pwmct_pkg.sv
// pwmct_pkg: register map, field positions and reset values of the pwm and capture timer.
// assumes a 16-bit register port addressed at the printed even offsets.
package pwmct_pkg;
   // ==========================================================================
   // register offsets
   localparam logic [15:0] OFS_COMPARE_A_VALUE = 16'h5300;
   localparam logic [15:0] OFS_COMPARE_B_VALUE = 16'h5302;
   localparam logic [15:0] OFS_COUNTER_VALUE = 16'h5304;
   localparam logic [15:0] OFS_TIMER_CONTROL = 16'h5306;
   localparam logic [15:0] OFS_COUNT_CLOCK_SELECT = 16'h5308;
   localparam logic [15:0] OFS_INTERRUPT_MASK = 16'h530a;
   localparam logic [15:0] OFS_INTERRUPT_FLAGS = 16'h530c;

   // ==========================================================================
   // timer_control bit positions
   localparam int CTL_TIMER_RUN = 0;
   localparam int CTL_TIMER_RESET_CMD = 1;
   localparam int CTL_OUTPUT_ENABLE = 2;
   localparam int CTL_COUNT_CLOCK_SOURCE = 3;
   localparam int CTL_INVERSE_OUTPUT = 4;
   localparam int CTL_COMPARE_BUFFER_ENABLE = 5;
   localparam int CTL_FINE_MODE_SELECT = 6;
   localparam int CTL_INITIAL_LEVEL = 8;

   // ==========================================================================
   // interrupt bit positions, shared by mask and flags
   localparam int IRQ_COMPARE_A = 0;
   localparam int IRQ_COMPARE_B = 1;

   // ==========================================================================
   // widths, reset values and the reserved divider code
   localparam int DIV_W = 4;
   localparam int PRESC_W = 14;
   localparam logic [15:0] RESET_VALUE_16 = 16'h0000;
   localparam logic [DIV_W-1:0] RESET_DIV = 4'h0;
   localparam logic [DIV_W-1:0] DIV_RESERVED = 4'hf;
   localparam logic [1:0] RESET_IRQ_BITS = 2'h0;
endpackage

// file: rtl/pwmct_timer.sv
// pwmct_timer: 16-bit pwm and capture timer with register port, prescaler and interrupt.
// assumes a one-cycle register port master on sys_clk; ext_clk_in is asynchronous.
//
// Summary of operation
// R1: all seven registers are 16 bits wide, at even offsets 0x5300 to 0x530c.
// R2: software writes zero to reserved bits; the block does not depend on it.
// R3: buffer disabled: compare offsets access the active compare registers directly.
// R4: buffer enabled: compare a offset uses a shadow, loaded on counter reset.
// R5: buffer enabled: compare b offset uses a shadow, loaded on counter reset.
// R6: shadow load happens on software reset and on compare b match reset.
// R7: counter equal compare a: flag a, output goes active, counting continues.
// R8: counter equal compare b: flag b, output goes active, counter clears to zero.
// R9: counter is readable, writable by software, and resets to zero.
// R10: output disabled or timer reset: pin takes initial level, inverted by inverse bit.
// R11: fine mode gives half count clock steps of output duty.
// R12: inverse bit makes output active low and inverts the off level.
// R13: clock source bit selects external clock (1) or internal prescaler (0).
// R14: fine mode matches compare a 15:1 to counter 14:0; bit 0 picks edge.
// R15: run bit starts counting; stop keeps the count for resuming.
// R16: timer reset bit is write-only, clears the counter, reads as zero.
// R17: reserved bits ignore writes and read as zero.
`timescale 1ns/10ps
`default_nettype none
module pwmct_timer (
   input wire logic sys_clk, // 10 MHz system clock
   input wire logic reset_n, // asynchronous reset, active low
   input wire logic [15:0] reg_addr, // register byte offset
   input wire logic [15:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe, one cycle
   input wire logic reg_rd, // read strobe, one cycle
   output logic [15:0] reg_rdata, // read data, cycle after the strobe
   input wire logic ext_clk_in, // external count clock pin
   output logic timer_output_pin, // timer output
   output logic irq // level interrupt request
);

   // ==========================================================================
   // state
   typedef struct packed {
      logic [15:0] cmp_a; // active compare a
      logic [15:0] cmp_b; // active compare b
      logic [15:0] buf_a; // compare a shadow
      logic [15:0] buf_b; // compare b shadow
      logic [15:0] cnt;
      logic timer_run;
      logic output_enable;
      logic count_clock_source;
      logic inverse_output;
      logic compare_buffer_enable;
      logic fine_mode_select;
      logic initial_level;
      logic [pwmct_pkg::DIV_W-1:0] div_sel;
      logic [1:0] irq_mask;
      logic [1:0] irq_flags;
      logic [pwmct_pkg::PRESC_W-1:0] presc;
      logic ext_s1;
      logic ext_s2;
      logic ext_s3;
      logic ext_lvl; // filtered external clock level
      logic raw_lvl; // output level before inversion
      logic fine_pend; // output change waiting for the falling edge
      logic pin;
      logic irq;
      logic [15:0] rdata;
   } pwmct_state_t;

   pwmct_state_t state_reg;
   pwmct_state_t state_next;
   logic rst_s1_reg;
   logic rst_n_sync_reg;

   // ==========================================================================
   // reset release through two flops
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_s1_reg <= 1'b0;
         rst_n_sync_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_n_sync_reg <= rst_s1_reg;
      end
   end

   // ==========================================================================
   // next state
   always_comb begin
      logic [pwmct_pkg::PRESC_W:0] one_hot;
      logic [pwmct_pkg::PRESC_W-1:0] dmask;
      logic ext_stable;
      logic ext_rise;
      logic ext_fall;
      logic int_tick;
      logic int_half;
      logic tick;
      logic half;
      logic match_a;
      logic match_b;
      logic [1:0] irq_set;
      logic wr_ctl;
      logic load_shadow;
      one_hot = '0;
      dmask = '0;
      ext_stable = 1'b0;
      ext_rise = 1'b0;
      ext_fall = 1'b0;
      int_tick = 1'b0;
      int_half = 1'b0;
      tick = 1'b0;
      half = 1'b0;
      match_a = 1'b0;
      match_b = 1'b0;
      irq_set = 2'h0;
      wr_ctl = 1'b0;
      load_shadow = 1'b0;
      state_next = state_reg;

      // external clock: three flops, a change counts when the last two agree
      state_next.ext_s1 = ext_clk_in;
      state_next.ext_s2 = state_reg.ext_s1;
      state_next.ext_s3 = state_reg.ext_s2;
      ext_stable = (state_reg.ext_s2 == state_reg.ext_s3);
      if (ext_stable) begin
         state_next.ext_lvl = state_reg.ext_s3;
      end
      ext_rise = ext_stable && state_reg.ext_s3 && !state_reg.ext_lvl;
      ext_fall = ext_stable && !state_reg.ext_s3 && state_reg.ext_lvl;

      // free running prescaler; divide by 2^div_sel as a one-cycle enable
      state_next.presc = state_reg.presc + {{(pwmct_pkg::PRESC_W-1){1'b0}}, 1'b1};
      one_hot = {{pwmct_pkg::PRESC_W{1'b0}}, 1'b1} << state_reg.div_sel;
      dmask = one_hot[pwmct_pkg::PRESC_W-1:0] - {{(pwmct_pkg::PRESC_W-1){1'b0}}, 1'b1};
      int_tick = (state_reg.div_sel != pwmct_pkg::DIV_RESERVED) && ((state_reg.presc & dmask) == dmask);
      // mid-period enable stands in for the falling input edge; at divide by 1 it is the next cycle
      int_half = (state_reg.div_sel == pwmct_pkg::RESET_DIV) || ((state_reg.presc & dmask) == (dmask >> 1));

      // count clock choice
      tick = state_reg.count_clock_source ? ext_rise : int_tick; // [R13]
      half = state_reg.count_clock_source ? ext_fall : int_half;

      // a delayed fine-mode output change lands on the half-period edge
      if (state_reg.fine_pend && half) begin
         state_next.fine_pend = 1'b0;
         state_next.raw_lvl = 1'b1; // [R11]
      end

      // compare and count, only while running
      match_a = state_reg.fine_mode_select ? (state_reg.cmp_a[15:1] == state_reg.cnt[14:0]) // [R14]
                                           : (state_reg.cmp_a == state_reg.cnt);
      match_b = (state_reg.cmp_b == state_reg.cnt);
      if (state_reg.timer_run && tick) begin // [R15]
         if (match_b) begin
            state_next.cnt = pwmct_pkg::RESET_VALUE_16; // [R8]
            state_next.raw_lvl = 1'b1; // [R8]
            irq_set[pwmct_pkg::IRQ_COMPARE_B] = 1'b1; // [R8]
            load_shadow = state_reg.compare_buffer_enable; // [R6]
         end else begin
            state_next.cnt = state_reg.cnt + 16'h0001; // [R7]
         end
         if (match_a) begin
            irq_set[pwmct_pkg::IRQ_COMPARE_A] = 1'b1; // [R7]
            if (state_reg.fine_mode_select && state_reg.cmp_a[0]) begin
               state_next.fine_pend = 1'b1; // [R14]
            end else begin
               state_next.raw_lvl = 1'b1; // [R7]
            end
         end
      end

      // software writes override the count in the same cycle
      if (reg_wr) begin
         unique case (reg_addr) // [R1]
            pwmct_pkg::OFS_COMPARE_A_VALUE: begin
               state_next.buf_a = reg_wdata; // [R4]
               if (!state_reg.compare_buffer_enable) begin
                  state_next.cmp_a = reg_wdata; // [R3]
               end
            end
            pwmct_pkg::OFS_COMPARE_B_VALUE: begin
               state_next.buf_b = reg_wdata; // [R5]
               if (!state_reg.compare_buffer_enable) begin
                  state_next.cmp_b = reg_wdata; // [R3]
               end
            end
            pwmct_pkg::OFS_COUNTER_VALUE: begin
               state_next.cnt = reg_wdata; // [R9]
            end
            pwmct_pkg::OFS_TIMER_CONTROL: begin
               wr_ctl = 1'b1;
               // reserved bits are simply not stored
               state_next.timer_run = reg_wdata[pwmct_pkg::CTL_TIMER_RUN]; // [R15] [R17]
               state_next.output_enable = reg_wdata[pwmct_pkg::CTL_OUTPUT_ENABLE];
               state_next.count_clock_source = reg_wdata[pwmct_pkg::CTL_COUNT_CLOCK_SOURCE]; // [R13]
               state_next.inverse_output = reg_wdata[pwmct_pkg::CTL_INVERSE_OUTPUT]; // [R12]
               state_next.compare_buffer_enable = reg_wdata[pwmct_pkg::CTL_COMPARE_BUFFER_ENABLE];
               state_next.fine_mode_select = reg_wdata[pwmct_pkg::CTL_FINE_MODE_SELECT]; // [R11]
               state_next.initial_level = reg_wdata[pwmct_pkg::CTL_INITIAL_LEVEL]; // [R10]
            end
            pwmct_pkg::OFS_COUNT_CLOCK_SELECT: begin
               state_next.div_sel = reg_wdata[pwmct_pkg::DIV_W-1:0]; // [R17]
            end
            pwmct_pkg::OFS_INTERRUPT_MASK: begin
               state_next.irq_mask = reg_wdata[1:0]; // [R17]
            end
            default: begin
               // flags clear by read; unmapped writes are dropped
            end
         endcase
      end

      // timer reset command: clear counter, restore initial level, reload shadows
      if (wr_ctl && reg_wdata[pwmct_pkg::CTL_TIMER_RESET_CMD]) begin
         state_next.cnt = pwmct_pkg::RESET_VALUE_16; // [R16]
         state_next.raw_lvl = reg_wdata[pwmct_pkg::CTL_INITIAL_LEVEL]; // [R10]
         state_next.fine_pend = 1'b0;
         load_shadow = reg_wdata[pwmct_pkg::CTL_COMPARE_BUFFER_ENABLE]; // [R6]
      end

      // shadow to active transfer at counter reset
      if (load_shadow) begin
         state_next.cmp_a = state_reg.buf_a; // [R4]
         state_next.cmp_b = state_reg.buf_b; // [R5]
      end

      // sticky flags; a read clears them but a new event in the same cycle wins
      if (reg_rd && (reg_addr == pwmct_pkg::OFS_INTERRUPT_FLAGS)) begin
         state_next.irq_flags = irq_set;
      end else begin
         state_next.irq_flags = state_reg.irq_flags | irq_set;
      end

      // read data, registered so it stands exactly one cycle after the strobe
      state_next.rdata = 16'h0000;
      if (reg_rd) begin
         unique case (reg_addr)
            pwmct_pkg::OFS_COMPARE_A_VALUE: begin
               state_next.rdata = state_reg.compare_buffer_enable ? state_reg.buf_a : state_reg.cmp_a; // [R3] [R4]
            end
            pwmct_pkg::OFS_COMPARE_B_VALUE: begin
               state_next.rdata = state_reg.compare_buffer_enable ? state_reg.buf_b : state_reg.cmp_b; // [R3] [R5]
            end
            pwmct_pkg::OFS_COUNTER_VALUE: begin
               state_next.rdata = state_reg.cnt; // [R9]
            end
            pwmct_pkg::OFS_TIMER_CONTROL: begin
               // reset command bit always reads zero
               state_next.rdata[pwmct_pkg::CTL_TIMER_RUN] = state_reg.timer_run; // [R16] [R17]
               state_next.rdata[pwmct_pkg::CTL_OUTPUT_ENABLE] = state_reg.output_enable;
               state_next.rdata[pwmct_pkg::CTL_COUNT_CLOCK_SOURCE] = state_reg.count_clock_source;
               state_next.rdata[pwmct_pkg::CTL_INVERSE_OUTPUT] = state_reg.inverse_output;
               state_next.rdata[pwmct_pkg::CTL_COMPARE_BUFFER_ENABLE] = state_reg.compare_buffer_enable;
               state_next.rdata[pwmct_pkg::CTL_FINE_MODE_SELECT] = state_reg.fine_mode_select;
               state_next.rdata[pwmct_pkg::CTL_INITIAL_LEVEL] = state_reg.initial_level;
            end
            pwmct_pkg::OFS_COUNT_CLOCK_SELECT: begin
               state_next.rdata[pwmct_pkg::DIV_W-1:0] = state_reg.div_sel; // [R17]
            end
            pwmct_pkg::OFS_INTERRUPT_MASK: begin
               state_next.rdata[1:0] = state_reg.irq_mask;
            end
            pwmct_pkg::OFS_INTERRUPT_FLAGS: begin
               state_next.rdata[1:0] = state_reg.irq_flags;
            end
            default: begin
               state_next.rdata = 16'h0000; // unmapped reads return zero
            end
         endcase
      end

      // output pin: off level when disabled, polarity applied last
      if (state_next.output_enable) begin
         state_next.pin = state_next.raw_lvl ^ state_next.inverse_output; // [R12]
      end else begin
         state_next.pin = state_next.initial_level ^ state_next.inverse_output; // [R10]
      end
      state_next.irq = |(state_next.irq_flags & state_next.irq_mask);
   end

   // ==========================================================================
   // state register
   always_ff @(posedge sys_clk or negedge rst_n_sync_reg) begin
      if (!rst_n_sync_reg) begin
         state_reg <= '0; // all fields reset to zero, matching the register defaults [R9]
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================================================
   // outputs straight from flops
   assign reg_rdata = state_reg.rdata;
   assign timer_output_pin = state_reg.pin;
   assign irq = state_reg.irq;

endmodule
`default_nettype wire

// file: verif/pwmct_timer_assertions.sv
// pwmct_timer_assertions: port-level checks of the timer register port, pin and interrupt.
// assumes a one-cycle strobe master on sys_clk; attached by the bind at the foot.
`timescale 1ns/10ps
`default_nettype none
module pwmct_timer_assertions (
   input wire logic sys_clk, // system clock
   input wire logic reset_n, // reset, active low
   input wire logic [15:0] reg_addr, // register offset
   input wire logic [15:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [15:0] reg_rdata, // read data
   input wire logic ext_clk_in, // external count clock
   input wire logic timer_output_pin, // timer output
   input wire logic irq // level interrupt
);
   // ==========================================================================
   // decode helpers, kept outside the properties for readability
   logic is_ctl, is_cnt, is_msk, is_flg, is_clk, unmap, off_lvl;
   assign is_ctl = reg_addr == pwmct_pkg::OFS_TIMER_CONTROL;
   assign is_cnt = reg_addr == pwmct_pkg::OFS_COUNTER_VALUE;
   assign is_msk = reg_addr == pwmct_pkg::OFS_INTERRUPT_MASK;
   assign is_flg = reg_addr == pwmct_pkg::OFS_INTERRUPT_FLAGS;
   assign is_clk = reg_addr == pwmct_pkg::OFS_COUNT_CLOCK_SELECT;
   assign unmap = reg_addr[15:4] != 12'h530 || reg_addr[0] || reg_addr[3:1] == 3'h7;
   assign off_lvl = reg_wdata[8] ^ reg_wdata[4]; // off level as written
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);

   // ==========================================================================
   // register port
   chk_unmapped_zero: assert property (reg_rd && unmap |=> reg_rdata == 16'h0000)
      else $error("unmapped read returned data");
   chk_ctl_reserved: assert property (reg_rd && is_ctl |=>
      reg_rdata[15:9] == 7'h00 && !reg_rdata[7] && !reg_rdata[1]) else $error("control read shows stray bits");
   chk_irq_reserved: assert property (reg_rd && (is_msk || is_flg) |=> reg_rdata[15:2] == 14'h0000)
      else $error("mask or flag read shows stray bits");
   chk_div_reserved: assert property (reg_rd && is_clk |=> reg_rdata[15:4] == 12'h000)
      else $error("clock select read shows stray bits");
   chk_cnt_write: assert property (reg_wr && is_cnt ##1 reg_rd && is_cnt |=> reg_rdata == $past(reg_wdata, 2))
      else $error("counter write not read back");
   chk_reset_clear: assert property (reg_wr && is_ctl && reg_wdata[1] ##1 reg_rd && is_cnt |=>
      reg_rdata == 16'h0000) else $error("reset command left counter nonzero");
   chk_stop_hold: assert property (reg_wr && is_ctl && !reg_wdata[0] ##1 !reg_wr ##1 reg_rd && is_cnt ##1
      reg_rd && is_cnt |=> $stable(reg_rdata)) else $error("stopped counter moved");

   // ==========================================================================
   // pin and interrupt
   chk_off_level: assert property (reg_wr && is_ctl && !reg_wdata[2] ##1 !(reg_wr && is_ctl) |=>
      timer_output_pin == $past(off_lvl, 2)) else $error("pin not at off level");
   chk_irq_masked: assert property (reg_wr && is_msk && reg_wdata[1:0] == 2'h0 ##1
      !(reg_wr && is_msk) |=> !irq) else $error("masked interrupt still high");
   cover property (irq);
   cover property ($rose(timer_output_pin));
   cover property (reg_rd && is_flg ##1 reg_rdata[1:0] == 2'h3);
endmodule

bind pwmct_timer pwmct_timer_assertions u_chk (
   .sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
   .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_in(ext_clk_in),
   .timer_output_pin(timer_output_pin), .irq(irq)
);
`default_nettype wire

// file: verif/test_pwm_capture_timer_regs.sv
// test_pwm_capture_timer_regs: self-checking bench for the pwm timer.
// assumes pwmct_pkg and the bound checker are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module test_pwm_capture_timer_regs;
   localparam logic [15:0] CA = pwmct_pkg::OFS_COMPARE_A_VALUE;
   localparam logic [15:0] CB = pwmct_pkg::OFS_COMPARE_B_VALUE;
   localparam logic [15:0] CN = pwmct_pkg::OFS_COUNTER_VALUE;
   localparam logic [15:0] CT = pwmct_pkg::OFS_TIMER_CONTROL;
   localparam logic [15:0] CK = pwmct_pkg::OFS_COUNT_CLOCK_SELECT;
   localparam logic [15:0] MK = pwmct_pkg::OFS_INTERRUPT_MASK;
   localparam logic [15:0] FL = pwmct_pkg::OFS_INTERRUPT_FLAGS;
   logic sys_clk = 1'b0, reset_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ext_clk_in = 1'b0, rd_seen = 1'b0;
   logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, reg_rdata;
   logic timer_output_pin, irq;
   logic [15:0] exp_q[$];
   logic [15:0] r[4];
   int fails = 0, checks = 0;

   always #50 sys_clk = ~sys_clk;

   pwmct_timer u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ext_clk_in(ext_clk_in),
      .timer_output_pin(timer_output_pin), .irq(irq));

   // ==========================================================================
   // bus tasks; strobes stay up between calls so accesses can run back to back
   task chk(input logic [15:0] s, input logic [15:0] e);
      checks++;
      if (s !== e) begin
         fails++;
         $display("mismatch at %0t: saw %h, expected %h", $time, s, e);
      end
   endtask
   task wr(input logic [15:0] a, input logic [15:0] d);
      reg_wr <= 1'b1;
      reg_rd <= 1'b0;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
   endtask
   task rd(input logic [15:0] a, input logic [15:0] e);
      exp_q.push_back(e);
      reg_wr <= 1'b0;
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
   endtask
   task idle(input int n);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      repeat (n) @(posedge sys_clk);
   endtask
   // pins are looked at just past the edge so the registered outputs have landed
   task pins(input logic [1:0] e);
      #1;
      chk({14'h0000, timer_output_pin, irq}, {14'h0000, e});
   endtask
   task results;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // read data stands only in the cycle after the strobe, so compare there
   always @(posedge sys_clk) begin
      if (rd_seen) chk(reg_rdata, exp_q.pop_front());
      rd_seen <= reg_rd;
   end

   // watchdog, far beyond the roughly 155 cycles the sequence needs
   initial begin
      #3000000;
      fails++;
      results();
   end

   // ==========================================================================
   // main sequence
   initial begin
      void'($urandom(70));
      repeat (3) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      pins(2'b00);
      for (int i = 0; i < 7; i++) rd(CA + 16'(2 * i), 16'h0000);
      // reserved bits, reset command bit and unmapped places
      // software keeps reserved bits at zero, so only mapped bits are set here, except the all-ones write to the unmapped 0x530e
      wr(CT, 16'h0002);
      wr(CK, 16'h0000);
      wr(MK, 16'h0000);
      wr(16'h530e, 16'hffff);
      rd(CT, 16'h0000);
      rd(CK, 16'h0000);
      rd(MK, 16'h0000);
      rd(16'h530e, 16'h0000);
      rd(16'h5301, 16'h0000);
      // direct compare access, then shadows hide behind the active pair
      for (int i = 0; i < 4; i++) r[i] = 16'($urandom);
      wr(CA, r[0]);
      wr(CB, r[1]);
      rd(CA, r[0]);
      rd(CB, r[1]);
      wr(CN, r[2]);
      rd(CN, r[2]);
      wr(CT, 16'h0020);
      wr(CA, r[2]);
      wr(CB, r[3]);
      rd(CA, r[2]);
      rd(CB, r[3]);
      wr(CT, 16'h0000);
      rd(CA, r[0]);
      rd(CB, r[1]);
      wr(CT, 16'h0022);
      wr(CT, 16'h0000);
      rd(CA, r[2]);
      rd(CB, r[3]);
      // counting with both matches; b match reloads the buffered b value
      wr(CA, 16'h0002);
      wr(CB, 16'h0005);
      wr(MK, 16'h0003);
      wr(CT, 16'h0022);
      wr(CB, 16'h0009);
      wr(CT, 16'h0025);
      idle(20);
      pins(2'b11);
      wr(CT, 16'h0004);
      wr(MK, 16'h0000);
      idle(2);
      pins(2'b10);
      rd(FL, 16'h0003);
      rd(FL, 16'h0000);
      rd(CB, 16'h0009);
      wr(MK, 16'h0003);
      idle(2);
      pins(2'b10);
      wr(CT, 16'h0014);
      idle(2);
      pins(2'b00);
      wr(CT, 16'h0100);
      idle(2);
      pins(2'b10);
      wr(CT, 16'h0110);
      idle(2);
      pins(2'b00);
      // stop keeps the count, run resumes from it; the stopping edge still counts
      wr(CT, 16'h0002);
      rd(CN, 16'h0000);
      wr(CT, 16'h0001);
      wr(CT, 16'h0000);
      idle(1);
      rd(CN, 16'h0001);
      rd(CN, 16'h0001);
      wr(CT, 16'h0001);
      idle(3);
      wr(CT, 16'h0000);
      idle(1);
      rd(CN, 16'h0005);
      // external count clock, four slow pulses
      wr(CT, 16'h0002);
      wr(CT, 16'h0009);
      repeat (4) begin
         idle(4);
         ext_clk_in <= 1'b1;
         idle(4);
         ext_clk_in <= 1'b0;
      end
      idle(8);
      wr(CT, 16'h0000);
      idle(1);
      rd(CN, 16'h0004);
      // fine mode: compare a 15:1 meets count 1, bit 0 delays the edge by one cycle, a whole step at divide by 1
      wr(MK, 16'h0000);
      wr(CA, 16'h0003);
      wr(CB, 16'h0009);
      wr(CT, 16'h0047);
      idle(2);
      pins(2'b00);
      idle(1);
      pins(2'b10);
      wr(CT, 16'h0000);
      idle(2);
      results();
   end
endmodule
`default_nettype wire
